//--- design/mpd_dispatch.v
// motion procedure dispatcher: takes procedure requests from pins,
// software, capture and cam, decodes the stored procedure and
// drives the trajectory generator.
// assumes: generator answers with motion_done and motion_stopped;
// parameter port is the drive's keypad/communication path.
`include "mpd_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module mpd_dispatch #(
	parameter MS_CYCLES = `MPD_MS_NS / `MPD_CLK_NS
)(
	input wire clock, // drive control clock, 100 MHz
	input wire rst_n, // synchronous reset, active low
	input wire trig_pin, // procedure_trigger_input
	input wire [5:0] sel_pin, // procedure_select_inputs
	input wire stop_pin, // stop_input
	input wire home_pin, // homing_start_input
	input wire [3:0] event_pin, // event_inputs
	input wire estop_pin, // emergency_stop_input
	input wire fwd_limit_pin, // forward_limit_input
	input wire rev_limit_pin, // reverse_limit_input
	input wire capture_done, // capture engine finished, pulse
	input wire cam_disengage, // cam engine let go, pulse
	input wire motion_done, // generator reached speed/position
	input wire motion_stopped, // generator came to rest
	input wire [7:0] par_addr, // parameter word index
	input wire [31:0] par_wdata, // parameter write data
	input wire par_we, // parameter write strobe
	output reg [31:0] par_rdata_reg, // read data, one cycle late
	output reg cmd_start_reg, // start pulse to generator
	output reg [3:0] cmd_type_reg, // procedure type issued
	output reg [31:0] cmd_data_reg, // target speed or position
	output reg [15:0] cmd_speed_reg, // table speed for positioning
	output reg [15:0] cmd_acc_ms_reg, // acceleration time, ms
	output reg [15:0] cmd_dec_ms_reg, // deceleration time, ms
	output reg cmd_unit_pps_reg, // speed data in pulses/s
	output reg [1:0] cmd_calc_reg, // position calc option bits
	output reg cmd_stop_reg, // stop pulse to generator
	output reg [15:0] stop_ms_reg, // ramp time for a stop
	output reg cmd_done_reg, // command done output
	output reg [5:0] active_slot_reg, // procedure in hand
	output reg busy_reg // a procedure is in hand
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam ST_IDLE = 2'b00; // nothing in hand
localparam ST_RUN = 2'b01; // generator working
localparam ST_DELAY = 2'b10; // completion delay
localparam ST_STOP = 2'b11; // ramping down on a stop

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
reg [15:0] speed_tab [0:15]; // target_speed_table
reg [15:0] ramp_tab [0:15]; // ramp_time_table
reg [15:0] delay_tab [0:15]; // delay_time_table
reg [31:0] misc_reg [0:9]; // protection..reverse_soft_limit
reg [31:0] proc_mem [0:127]; // two words per slot
reg [31:0] cap_cfg_reg; // capture_config
reg [31:0] cam_cfg_reg; // cam_config
reg [31:0] rise_map_reg; // event_rise_map
reg [31:0] fall_map_reg; // event_fall_map
reg [31:0] sw_res_reg; // software_procedure_trigger readback
reg sw_own_reg; // procedure in hand came from software
reg [1:0] state_reg; // dispatcher state
reg [3:0] dly_idx_reg; // delay index of procedure in hand
reg chain_reg; // go to next slot when done
reg [15:0] ms_left_reg; // delay milliseconds remaining
reg [16:0] pre_reg; // cycles within current millisecond
reg pend_v_reg; // a request waits
reg [5:0] pend_num_reg; // slot that waits
reg pend_sw_reg; // waiting request came from software
integer i;
integer k; // event scan index

// ----------------------------------------------------------------
// pin conditioning
// ----------------------------------------------------------------
wire [15:0] pin_lvl; // accepted levels
wire [15:0] pin_rise; // rising pulses
wire [15:0] pin_fall; // falling pulses

mpd_in_sync #(.W(16)) u_sync (
	.clock(clock),
	.rst_n(rst_n),
	.pin_in({rev_limit_pin, fwd_limit_pin, estop_pin, event_pin,
		home_pin, stop_pin, sel_pin, trig_pin}),
	.level_out(pin_lvl),
	.rise_out(pin_rise),
	.fall_out(pin_fall)
);

// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
// slot number of one event in a map, one byte per event
function [5:0] ev_slot;
	input [31:0] map;
	input [1:0] n;
	begin
		ev_slot = map[{n, 3'b000} +: 6];
	end
endfunction

// first word of a slot
function [31:0] word0;
	input [5:0] s;
	begin
		word0 = proc_mem[{s, 1'b0}];
	end
endfunction

// ----------------------------------------------------------------
// software trigger write decode
// ----------------------------------------------------------------
wire sw_wr = par_we && (par_addr == `MPD_A_SWTRIG);
wire sw_go = sw_wr && (par_wdata[31:6] == 26'h0);
wire sw_stop = sw_wr && (par_wdata == `MPD_SW_STOP);
wire sw_bad = sw_wr && !sw_go && !sw_stop;

// ----------------------------------------------------------------
// request arbitration, stop first
// ----------------------------------------------------------------
wire stop_req = pin_rise[7] | pin_rise[13] | pin_rise[14] |
	pin_rise[15] | sw_stop;
reg req_v; // some start request this cycle
reg [5:0] req_num; // its slot
reg req_sw; // it came from software
reg ev_hit; // an event picked already

// homing, trigger, software, events, capture, cam in that order
always @*
begin
	req_v = 1'b1;
	req_num = `MPD_HOME_SLOT;
	req_sw = 1'b0;
	ev_hit = 1'b0;
	if (pin_rise[8])
		req_num = `MPD_HOME_SLOT;
	else if (pin_rise[0])
		req_num = pin_lvl[6:1];
	else if (sw_go)
	begin
		req_num = par_wdata[5:0];
		req_sw = 1'b1;
	end
	else if ((pin_rise[12:9] | pin_fall[12:9]) != 4'h0)
	begin
		for (k = 0; k < 4; k = k + 1)
		begin
			if (!ev_hit && pin_rise[9 + k])
			begin
				req_num = ev_slot(rise_map_reg, k[1:0]);
				ev_hit = 1'b1;
			end
			else if (!ev_hit && pin_fall[9 + k])
			begin
				req_num = ev_slot(fall_map_reg, k[1:0]);
				ev_hit = 1'b1;
			end
		end
	end
	else if (capture_done && cap_cfg_reg[`MPD_CAP_EN_BIT])
		req_num = `MPD_CAPTURE_SLOT;
	else if (cam_disengage)
		req_num = cam_cfg_reg[`MPD_CAM_PR_LSB +: 6];
	else
		req_v = 1'b0;
end

// ----------------------------------------------------------------
// launch decision
// ----------------------------------------------------------------
wire dly_end = (state_reg == ST_DELAY) && (ms_left_reg == 16'h0);
wire [31:0] req_w0 = word0(req_num); // first word of request
wire req_ins = req_w0[`MPD_F_INS];
reg launch; // start a slot this cycle
reg [5:0] launch_num; // which slot
reg launch_sw; // launched slot belongs to software
reg take_req; // the new request is consumed

// chain first, then insertion into a run, then idle starts
always @*
begin
	launch = 1'b0;
	launch_num = req_num;
	launch_sw = req_sw;
	take_req = 1'b0;
	if (dly_end && chain_reg && active_slot_reg != `MPD_LAST_SLOT)
	begin
		launch = 1'b1;
		launch_num = active_slot_reg + 6'h01;
		launch_sw = 1'b0;
	end
	else if (req_v && state_reg == ST_RUN && req_ins)
	begin
		launch = 1'b1;
		take_req = 1'b1;
	end
	else if (req_v && state_reg == ST_IDLE)
	begin
		launch = 1'b1;
		take_req = 1'b1;
	end
	else if (pend_v_reg && state_reg == ST_IDLE)
	begin
		launch = 1'b1;
		launch_num = pend_num_reg;
		launch_sw = pend_sw_reg;
	end
end

// fields of the slot being launched
wire [31:0] l_w0 = proc_mem[{launch_num, 1'b0}];
wire [31:0] l_w1 = proc_mem[{launch_num, 1'b1}];
wire [3:0] l_type = l_w0[`MPD_F_TYPE_LSB +: 4];
wire l_motion = (launch_num == `MPD_HOME_SLOT) ||
	(l_type == `MPD_T_SPEED) || (l_type == `MPD_T_POS_STOP) ||
	(l_type == `MPD_T_POS_NEXT);

// ----------------------------------------------------------------
// dispatcher
// ----------------------------------------------------------------
always @(posedge clock)
begin
	if (!rst_n)
	begin
		state_reg <= ST_IDLE;
		cmd_start_reg <= 1'b0;
		cmd_type_reg <= 4'h0;
		cmd_data_reg <= 32'h0;
		cmd_speed_reg <= 16'h0;
		cmd_acc_ms_reg <= 16'h0;
		cmd_dec_ms_reg <= 16'h0;
		cmd_unit_pps_reg <= 1'b0;
		cmd_calc_reg <= 2'h0;
		cmd_stop_reg <= 1'b0;
		stop_ms_reg <= 16'h0;
		cmd_done_reg <= 1'b1;
		active_slot_reg <= 6'h0;
		busy_reg <= 1'b0;
		dly_idx_reg <= 4'h0;
		chain_reg <= 1'b0;
		ms_left_reg <= 16'h0;
		pre_reg <= 17'h0;
		pend_v_reg <= 1'b0;
		pend_num_reg <= 6'h0;
		pend_sw_reg <= 1'b0;
		sw_own_reg <= 1'b0;
		sw_res_reg <= 32'h0;
	end
	else
	begin
		cmd_start_reg <= 1'b0;
		cmd_stop_reg <= 1'b0;
		pre_reg <= 17'h0;
		// a request that could not start waits for idle
		if (req_v && !take_req && !stop_req)
		begin
			pend_v_reg <= 1'b1;
			pend_num_reg <= req_num;
			pend_sw_reg <= req_sw;
		end
		else if (launch && !take_req && !stop_req && state_reg == ST_IDLE)
			pend_v_reg <= 1'b0;
		if (sw_bad)
			sw_res_reg <= `MPD_RES_BAD;
		if (stop_req)
		begin
			// stop wins over any start in this cycle
			cmd_stop_reg <= 1'b1;
			stop_ms_reg <= ramp_tab[misc_reg[3][3:0]];
			pend_v_reg <= 1'b0;
			chain_reg <= 1'b0;
			busy_reg <= 1'b1;
			state_reg <= ST_STOP;
			if (sw_own_reg)
				sw_res_reg <= `MPD_RES_STOPPED;
		end
		else if (launch)
		begin
			cmd_start_reg <= l_motion;
			cmd_type_reg <= (launch_num == `MPD_HOME_SLOT) ?
				`MPD_T_HOME : l_type;
			cmd_data_reg <= l_w1;
			cmd_speed_reg <= speed_tab[l_w0[`MPD_F_SPD_LSB +: 4]];
			cmd_acc_ms_reg <= ramp_tab[l_w0[`MPD_F_ACC_LSB +: 4]];
			cmd_dec_ms_reg <= ramp_tab[l_w0[`MPD_F_DEC_LSB +: 4]];
			cmd_unit_pps_reg <= (l_type == `MPD_T_SPEED) &&
				l_w0[`MPD_F_UNIT];
			cmd_calc_reg <= l_w0[7:6];
			cmd_done_reg <= 1'b0;
			active_slot_reg <= launch_num;
			busy_reg <= 1'b1;
			dly_idx_reg <= l_w0[`MPD_F_DLY_LSB +: 4];
			chain_reg <= (l_type == `MPD_T_POS_NEXT) ||
				((l_type == `MPD_T_SPEED) && l_w0[`MPD_F_AUTO]);
			if (launch_num == `MPD_HOME_SLOT)
				chain_reg <= 1'b0;
			ms_left_reg <= delay_tab[l_w0[`MPD_F_DLY_LSB +: 4]];
			sw_own_reg <= launch_sw;
			if (launch_sw)
				sw_res_reg <= `MPD_RES_BUSY;
			state_reg <= l_motion ? ST_RUN : ST_DELAY;
		end
		else
		begin
			case (state_reg)
				ST_RUN:
				begin
					// speed reached or position reached
					if (motion_done)
					begin
						ms_left_reg <= delay_tab[dly_idx_reg];
						state_reg <= ST_DELAY;
					end
				end
				ST_DELAY:
				begin
					// count milliseconds, then report done
					if (dly_end)
					begin
						cmd_done_reg <= 1'b1;
						busy_reg <= 1'b0;
						state_reg <= ST_IDLE;
						if (sw_own_reg)
							sw_res_reg <= `MPD_RES_DONE;
					end
					else if (pre_reg == MS_CYCLES[16:0] - 17'h1)
						ms_left_reg <= ms_left_reg - 16'h1;
					else
						pre_reg <= pre_reg + 17'h1;
				end
				ST_STOP:
				begin
					// ramp down finished
					if (motion_stopped)
					begin
						cmd_done_reg <= 1'b1;
						busy_reg <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default:
					busy_reg <= 1'b0;
			endcase
		end
	end
end

// ----------------------------------------------------------------
// parameter writes, out-of-range values ignored
// ----------------------------------------------------------------
always @(posedge clock)
begin
	if (!rst_n)
	begin
		for (i = 0; i < 16; i = i + 1)
		begin
			speed_tab[i] <= `MPD_SPEED_RST;
			ramp_tab[i] <= `MPD_RAMP_RST;
			delay_tab[i] <= `MPD_DELAY_RST;
		end
		for (i = 0; i < 10; i = i + 1)
			misc_reg[i] <= 32'h0;
		for (i = 0; i < 128; i = i + 1)
			proc_mem[i] <= 32'h0;
		cap_cfg_reg <= 32'h0;
		cam_cfg_reg <= 32'h0;
		rise_map_reg <= 32'h0;
		fall_map_reg <= 32'h0;
	end
	else if (par_we)
	begin
		if (par_addr[7:4] == 4'h0 && par_wdata[15:0] >= `MPD_SPEED_MIN
			&& par_wdata[15:0] <= `MPD_SPEED_MAX)
			speed_tab[par_addr[3:0]] <= par_wdata[15:0];
		else if (par_addr[7:4] == 4'h1 && par_wdata[15:0] >=
			`MPD_RAMP_MIN && par_wdata[15:0] <= `MPD_RAMP_MAX)
			ramp_tab[par_addr[3:0]] <= par_wdata[15:0];
		else if (par_addr[7:4] == 4'h2 &&
			par_wdata[15:0] <= `MPD_DELAY_MAX)
			delay_tab[par_addr[3:0]] <= par_wdata[15:0];
		else if (par_addr >= `MPD_A_MISC && par_addr <=
			`MPD_A_MISC_LAST && par_addr[3:0] > `MPD_MISC_RSVD_LAST
			&& par_addr != `MPD_A_SWTRIG)
			misc_reg[par_addr[3:0]] <= par_wdata;
		else if (par_addr == `MPD_A_CAPCFG)
			cap_cfg_reg <= par_wdata;
		else if (par_addr == `MPD_A_CAMCFG)
			cam_cfg_reg <= par_wdata;
		else if (par_addr == `MPD_A_RISEMAP)
			rise_map_reg <= par_wdata;
		else if (par_addr == `MPD_A_FALLMAP)
			fall_map_reg <= par_wdata;
		else if (par_addr[7])
			proc_mem[par_addr[6:0]] <= par_wdata;
	end
end

// ----------------------------------------------------------------
// parameter reads, reserved and unmapped read zero
// ----------------------------------------------------------------
always @(posedge clock)
begin
	if (!rst_n)
		par_rdata_reg <= 32'h0;
	else if (par_addr[7])
		par_rdata_reg <= proc_mem[par_addr[6:0]];
	else if (par_addr[7:4] == 4'h0)
		par_rdata_reg <= {16'h0, speed_tab[par_addr[3:0]]};
	else if (par_addr[7:4] == 4'h1)
		par_rdata_reg <= {16'h0, ramp_tab[par_addr[3:0]]};
	else if (par_addr[7:4] == 4'h2)
		par_rdata_reg <= {16'h0, delay_tab[par_addr[3:0]]};
	else if (par_addr == `MPD_A_SWTRIG)
		par_rdata_reg <= sw_res_reg;
	else if (par_addr >= `MPD_A_MISC && par_addr <= `MPD_A_MISC_LAST
		&& par_addr[3:0] > `MPD_MISC_RSVD_LAST)
		par_rdata_reg <= misc_reg[par_addr[3:0]];
	else if (par_addr == `MPD_A_CAPCFG)
		par_rdata_reg <= cap_cfg_reg;
	else if (par_addr == `MPD_A_CAMCFG)
		par_rdata_reg <= cam_cfg_reg;
	else if (par_addr == `MPD_A_RISEMAP)
		par_rdata_reg <= rise_map_reg;
	else if (par_addr == `MPD_A_FALLMAP)
		par_rdata_reg <= fall_map_reg;
	else
		par_rdata_reg <= 32'h0;
end

endmodule
`default_nettype wire

//--- design/mpd_defines.vh
// constants for the motion procedure dispatcher: parameter map,
// procedure word fields, request codes and timing.
// assumes: included by bare name from design files under design/.
`ifndef MPD_DEFINES_VH
`define MPD_DEFINES_VH

// ----------------------------------------------------------------
// procedure slots
// ----------------------------------------------------------------
`define MPD_SLOTS 64
`define MPD_LAST_SLOT 6'h3f
`define MPD_HOME_SLOT 6'h00
`define MPD_CAPTURE_SLOT 6'h32

// ----------------------------------------------------------------
// parameter port map (word index on par_addr)
// ----------------------------------------------------------------
`define MPD_A_SPEED 8'h00
`define MPD_A_RAMP 8'h10
`define MPD_A_DELAY 8'h20
`define MPD_A_MISC 8'h30
`define MPD_A_MISC_LAST 8'h39
`define MPD_A_SWTRIG 8'h37
`define MPD_A_PROTDEC 8'h33
`define MPD_A_CAPCFG 8'h3a
`define MPD_A_CAMCFG 8'h3b
`define MPD_A_RISEMAP 8'h3c
`define MPD_A_FALLMAP 8'h3d
`define MPD_A_PROC 8'h80
`define MPD_MISC_RSVD_LAST 4'h2

// ----------------------------------------------------------------
// table ranges and reset values
// ----------------------------------------------------------------
`define MPD_SPEED_MIN 16'h0001
`define MPD_SPEED_MAX 16'hea60
`define MPD_RAMP_MIN 16'h0001
`define MPD_RAMP_MAX 16'hffdc
`define MPD_DELAY_MAX 16'h7fff
`define MPD_SPEED_RST 16'h03e8
`define MPD_RAMP_RST 16'h00c8
`define MPD_DELAY_RST 16'h0000

// ----------------------------------------------------------------
// first word fields, then capture and cam config bits
// ----------------------------------------------------------------
`define MPD_F_TYPE_LSB 0
`define MPD_F_INS 4
`define MPD_F_AUTO 5
`define MPD_F_UNIT 6
`define MPD_F_ACC_LSB 8
`define MPD_F_DEC_LSB 12
`define MPD_F_SPD_LSB 16
`define MPD_F_DLY_LSB 20
`define MPD_CAP_EN_BIT 3
`define MPD_CAM_PR_LSB 0

// ----------------------------------------------------------------
// procedure types (homing is what slot zero issues)
// ----------------------------------------------------------------
`define MPD_T_HOME 4'h0
`define MPD_T_SPEED 4'h1
`define MPD_T_POS_STOP 4'h2
`define MPD_T_POS_NEXT 4'h3

// ----------------------------------------------------------------
// software trigger codes
// ----------------------------------------------------------------
`define MPD_SW_STOP 32'h000003e8
`define MPD_RES_BUSY 32'h00010000
`define MPD_RES_DONE 32'h00020000
`define MPD_RES_BAD 32'h00030000
`define MPD_RES_STOPPED 32'h00040000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MPD_CLK_NS 10
`define MPD_MS_NS 1000000

`endif

//--- design/mpd_in_sync.v
// pin conditioner: three-stage synchroniser with agreement filter,
// then edge detection against the previous accepted level.
// assumes: pins are asynchronous to clock; rst_n is synchronous.
`timescale 1ns/1ns
`default_nettype none

module mpd_in_sync #(
	parameter W = 1
)(
	input wire clock, // drive control clock
	input wire rst_n, // synchronous reset, active low
	input wire [W-1:0] pin_in, // raw pin levels
	output reg [W-1:0] level_out, // accepted level
	output wire [W-1:0] rise_out, // one-cycle rising pulse
	output wire [W-1:0] fall_out // one-cycle falling pulse
);

// ----------------------------------------------------------------
// synchroniser and filter
// ----------------------------------------------------------------
reg [W-1:0] s1_reg; // first stage, read only by s2
reg [W-1:0] s2_reg; // second stage
reg [W-1:0] s3_reg; // third stage
reg [W-1:0] prev_reg; // accepted level one cycle back

// a bit changes only once stages two and three agree
always @(posedge clock)
begin
	if (!rst_n)
	begin
		s1_reg <= {W{1'b0}};
		s2_reg <= {W{1'b0}};
		s3_reg <= {W{1'b0}};
		level_out <= {W{1'b0}};
		prev_reg <= {W{1'b0}};
	end
	else
	begin
		s1_reg <= pin_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		level_out <= (s2_reg & ~(s2_reg ^ s3_reg)) |
			(level_out & (s2_reg ^ s3_reg));
		prev_reg <= level_out;
	end
end

// ----------------------------------------------------------------
// edges: registered level against its previous value
// ----------------------------------------------------------------
assign rise_out = level_out & ~prev_reg;
assign fall_out = ~level_out & prev_reg;

endmodule
`default_nettype wire

//--- testbench/mpd_asserts.sv
// checker for the procedure dispatcher, sees only its ports
// assumes: bound to mpd_dispatch; one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none
module mpd_asserts (
	input wire logic clock, // drive clock
	input wire logic rst_n, // reset, active low
	input wire logic trig_pin, // trigger pin
	input wire logic stop_pin, // stop pin
	input wire logic home_pin, // homing pin
	input wire logic cmd_start_reg, // start pulse
	input wire logic cmd_stop_reg, // stop pulse
	input wire logic cmd_done_reg, // done level
	input wire logic busy_reg, // busy level
	input wire logic [3:0] cmd_type_reg, // issued type
	input wire logic [5:0] active_slot_reg // issued slot
);
	// ----------------------------------------
	// one clock domain for all checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	start_done_a: assert property (cmd_start_reg |-> !cmd_done_reg && busy_reg)
		else $error("done high or idle at start");
	rst_done_a: assert property ($rose(rst_n) |-> cmd_done_reg && !busy_reg)
		else $error("bad state after reset");
	idle_done_a: assert property ($fell(busy_reg) |-> cmd_done_reg)
		else $error("idle without done");
	stop_resp_a: assert property ($rose(stop_pin) && busy_reg && !cmd_done_reg
		|-> ##[1:8] cmd_stop_reg)
		else $error("stop pin ignored");
	trig_resp_a: assert property ($rose(trig_pin) && !busy_reg && !stop_pin
		&& !home_pin |-> ##[2:8] cmd_start_reg)
		else $error("trigger ignored");
	home_resp_a: assert property ($rose(home_pin) && !busy_reg && !stop_pin
		|-> ##[2:8] cmd_start_reg && active_slot_reg == 6'h00)
		else $error("homing not started");
	home_type_a: assert property (cmd_start_reg && active_slot_reg == 6'h00
		|-> cmd_type_reg == 4'h0)
		else $error("slot zero not homing");
	stop_first_a: assert property (!(cmd_start_reg && cmd_stop_reg))
		else $error("start together with stop");
endmodule
bind mpd_dispatch mpd_asserts mpd_asserts_i (.clock(clock), .rst_n(rst_n),
	.trig_pin(trig_pin), .stop_pin(stop_pin), .home_pin(home_pin),
	.cmd_start_reg(cmd_start_reg), .cmd_stop_reg(cmd_stop_reg),
	.cmd_done_reg(cmd_done_reg), .busy_reg(busy_reg),
	.cmd_type_reg(cmd_type_reg), .active_slot_reg(active_slot_reg));
`default_nettype wire

//--- testbench/mpd_host.sv
// host pins and trajectory answers at the dispatcher's far side
// assumes: bench calls drive(); lat of zero means target never reached
`timescale 1ns/1ns
`default_nettype none
module mpd_host (
	input wire logic clock, // drive clock
	input wire logic cmd_start_reg, // start pulse
	input wire logic cmd_stop_reg, // stop pulse
	output logic trig_pin, // trigger
	output logic [5:0] sel_pin, // select lines
	output logic stop_pin, // stop
	output logic home_pin, // homing start
	output logic [3:0] event_pin, // events
	output logic motion_done, // target reached
	output logic motion_stopped // at rest
);
	int lat = 3; // cycles to reach target
	int dcnt = 0; // reach countdown
	int scnt = 0; // stop countdown
	initial {trig_pin, sel_pin, stop_pin, home_pin, event_pin} = 13'h0;
	// pins move just after an edge; select set before trigger rise
	task drive(input logic t, input logic [5:0] s, input logic st,
		input logic h, input logic [3:0] e);
		@(posedge clock);
		#1 {trig_pin, sel_pin, stop_pin, home_pin, event_pin} = {t, s, st, h, e};
	endtask
	// one-cycle answers; a stop cancels a pending reach
	always @(posedge clock)
	begin
		motion_done <= (dcnt == 1);
		motion_stopped <= (scnt == 1);
		dcnt <= cmd_stop_reg ? 0 : cmd_start_reg ? lat : dcnt ? dcnt - 1 : 0;
		scnt <= cmd_stop_reg ? 3 : scnt ? scnt - 1 : 0;
	end
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the procedure dispatcher
// assumes: mpd_host at the pins, millisecond cut to 4 cycles
`timescale 1ns/1ns
`default_nettype none
`include "mpd_defines.vh"
module tb;
	logic clock = 0; // 100 MHz clock
	logic rst_n = 0; // reset, active low
	logic capture_done = 0; // capture finished
	logic cam_disengage = 0; // cam released
	logic [7:0] par_addr = 0; // parameter index
	logic [31:0] par_wdata = 0; // parameter data
	logic par_we = 0; // write strobe
	logic estop_pin = 0; // emergency stop
	wire [1:0] cmd_calc_reg; // position calc bits
	wire trig_pin, stop_pin, home_pin, motion_done, motion_stopped;
	wire [5:0] sel_pin, active_slot_reg;
	wire [3:0] event_pin, cmd_type_reg;
	wire [31:0] par_rdata_reg, cmd_data_reg;
	wire [15:0] cmd_speed_reg, cmd_acc_ms_reg, cmd_dec_ms_reg, stop_ms_reg;
	wire cmd_start_reg, cmd_stop_reg, cmd_unit_pps_reg, cmd_done_reg, busy_reg;
	wire [2:0] sigs = {cmd_done_reg, cmd_stop_reg, cmd_start_reg}; // waitable
	int num_errors = 0; // mismatches
	int comparisons = 0; // checks made
	// ramps 7/9, delay 8 cycles, slots 3-7 and 50, maps, capture, cam
	logic [39:0] setup [16] = '{{8'h11, 32'h7}, {8'h12, 32'h9},
		{8'h21, 32'h2}, {8'h33, 32'h2}, {8'h86, 32'h2182}, {8'h87, 32'h1234},
		{8'h88, 32'h100041}, {8'h89, 32'h55}, {8'h8a, 32'h3}, {8'h8c, 32'h12},
		{8'he4, 32'h2}, {8'h3c, 32'h3}, {8'h3d, 32'h4}, {8'h3a, 32'h8},
		{8'h3b, 32'h7}, {8'h8e, 32'h21}};
	always #5 clock = ~clock;
	mpd_dispatch #(.MS_CYCLES(4)) mpd_dispatch_i (.clock(clock), .rst_n(rst_n),
		.trig_pin(trig_pin), .sel_pin(sel_pin), .stop_pin(stop_pin),
		.home_pin(home_pin), .event_pin(event_pin), .estop_pin(estop_pin),
		.fwd_limit_pin(1'b0), .rev_limit_pin(1'b0), .capture_done(capture_done),
		.cam_disengage(cam_disengage), .motion_done(motion_done),
		.motion_stopped(motion_stopped), .par_addr(par_addr),
		.par_wdata(par_wdata), .par_we(par_we), .par_rdata_reg(par_rdata_reg),
		.cmd_start_reg(cmd_start_reg), .cmd_type_reg(cmd_type_reg),
		.cmd_data_reg(cmd_data_reg), .cmd_speed_reg(cmd_speed_reg),
		.cmd_acc_ms_reg(cmd_acc_ms_reg), .cmd_dec_ms_reg(cmd_dec_ms_reg),
		.cmd_unit_pps_reg(cmd_unit_pps_reg), .cmd_calc_reg(cmd_calc_reg),
		.cmd_stop_reg(cmd_stop_reg), .stop_ms_reg(stop_ms_reg),
		.cmd_done_reg(cmd_done_reg), .active_slot_reg(active_slot_reg),
		.busy_reg(busy_reg));
	mpd_host mpd_host_i (.clock(clock), .cmd_start_reg(cmd_start_reg),
		.cmd_stop_reg(cmd_stop_reg), .trig_pin(trig_pin), .sel_pin(sel_pin),
		.stop_pin(stop_pin), .home_pin(home_pin), .event_pin(event_pin),
		.motion_done(motion_done), .motion_stopped(motion_stopped));
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		#1 {par_addr, par_wdata, par_we} = {a, d, 1'b1};
		@(posedge clock);
		#1 par_we = 0;
	endtask
	task rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		#1 par_addr = a;
		@(posedge clock);
		#1 chk(what, exp, par_rdata_reg);
	endtask
	// bounded wait: 0 start, 1 stop, 2 done; looks before stepping
	task wt(input int which, input int lim);
		for (int i = 0; i < lim && sigs[which] !== 1'b1; i++)
		begin
			@(posedge clock);
			#1;
		end
	endtask
	task launched(input string what, input logic [5:0] slot);
		wt(0, 12);
		chk(what, {1'b1, slot}, {cmd_start_reg, active_slot_reg});
		wt(2, 20);
	endtask
	task t_regs; // table defaults, refused writes, programming
		rchk("ramp0", `MPD_A_RAMP, {16'h0, `MPD_RAMP_RST});
		wr(8'h10, 32'h5);
		wr(8'h10, 32'h0);
		rchk("ramp0 kept", 8'h10, 32'h5);
		wr(8'h00, 32'hea61);
		rchk("speed0", 8'h00, 32'h3e8);
		wr(8'h2f, 32'h8000);
		rchk("delay15", 8'h2f, 32'h0);
		foreach (setup[i]) wr(setup[i][39:32], setup[i][31:0]);
	endtask
	task t_trig; // pin trigger of a stop-at-target slot
		mpd_host_i.drive(0, 6'h3, 0, 0, 4'h0);
		mpd_host_i.drive(1, 6'h3, 0, 0, 4'h0);
		wt(0, 12);
		chk("slot", {1'b1, 6'h3}, {cmd_start_reg, active_slot_reg});
		chk("type", 6'h22, {cmd_calc_reg, cmd_type_reg});
		chk("data", 32'h1234, cmd_data_reg);
		chk("speed", 32'h3e8, cmd_speed_reg);
		chk("ramps", 32'h90007, {cmd_dec_ms_reg, cmd_acc_ms_reg});
		wt(2, 12);
		chk("done", 2'b10, {cmd_done_reg, busy_reg});
		mpd_host_i.drive(0, 6'h3, 0, 0, 4'h0);
	endtask
	task t_sw; // software start, delay before done, result codes
		wr(`MPD_A_SWTRIG, 32'h4);
		chk("sw start", 3'b111, {cmd_start_reg, cmd_type_reg[0], cmd_unit_pps_reg});
		rchk("busy code", `MPD_A_SWTRIG, `MPD_RES_BUSY);
		repeat (5) @(posedge clock);
		#1 chk("in delay", 0, cmd_done_reg);
		wt(2, 16);
		rchk("done code", `MPD_A_SWTRIG, `MPD_RES_DONE);
		wr(`MPD_A_SWTRIG, 32'h40);
		rchk("bad code", `MPD_A_SWTRIG, `MPD_RES_BAD);
		wr(`MPD_A_SWTRIG, 32'h5);
		chk("chain first", 5, active_slot_reg);
		#10 launched("chain next", 6'h6);
	endtask
	task t_stop; // insertion and stop pin mid-run, emergency stop while idle
		mpd_host_i.lat = 0;
		mpd_host_i.drive(1, 6'h3, 0, 0, 4'h0);
		wt(0, 12);
		wr(`MPD_A_SWTRIG, 32'h6);
		chk("insert", 6, active_slot_reg);
		mpd_host_i.drive(1, 6'h3, 1, 0, 4'h0);
		wt(1, 12);
		chk("stop ramp", {1'b1, 16'h9}, {cmd_stop_reg, stop_ms_reg});
		wt(2, 12);
		chk("stopped", 0, busy_reg);
		rchk("stop code", `MPD_A_SWTRIG, `MPD_RES_STOPPED);
		estop_pin = 1;
		wt(1, 12);
		chk("estop", 1, cmd_stop_reg);
		mpd_host_i.lat = 3;
		mpd_host_i.drive(0, 6'h3, 0, 0, 4'h0);
	endtask
	task t_other; // homing, event edges, capture and cam starts
		mpd_host_i.drive(0, 6'h0, 0, 1, 4'h0);
		launched("home", 6'h0);
		mpd_host_i.drive(0, 6'h0, 0, 0, 4'h1);
		launched("ev rise", 6'h3);
		mpd_host_i.drive(0, 6'h0, 0, 0, 4'h0);
		launched("ev fall", 6'h4);
		@(posedge clock);
		#1 capture_done = 1;
		@(posedge clock);
		#1 capture_done = 0;
		launched("capture", `MPD_CAPTURE_SLOT);
		@(posedge clock);
		#1 cam_disengage = 1;
		@(posedge clock);
		#1 cam_disengage = 0;
		launched("cam", 6'h7);
		chk("auto chain", 8, active_slot_reg);
	endtask
	task results;
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clock);
		#1 rst_n = 1;
		repeat (6) @(posedge clock);
		t_regs;
		t_trig;
		t_sw;
		t_stop;
		t_other;
		results;
	end
	initial
	begin
		#100000 num_errors++;
		results;
	end
endmodule
`default_nettype wire
